/* File: hw/mapbam_pkg.sv */
package mapbam_pkg;

  // Register offsets on the local register port (byte addresses, one word each).
  localparam logic [7:0] OFS_CW_AHB3  = 8'h00;
  localparam logic [7:0] OFS_CW_AHB5  = 8'h04;
  localparam logic [7:0] OFS_CW_APB23 = 8'h08;
  localparam logic [7:0] OFS_CW_APB4  = 8'h0c;
  localparam logic [7:0] OFS_BARRIER  = 8'h10;
  localparam logic [7:0] OFS_BAR_CTRL = 8'h14;

  // Control-word field positions.
  localparam int POS_NONSEC   = 30;
  localparam int POS_MSEL     = 29;
  localparam int POS_PROT_HI  = 30;
  localparam int POS_PROT_LO  = 24;
  localparam int POS_SDE      = 23;
  localparam int POS_INC_HI   = 5;
  localparam int POS_INC_LO   = 4;
  localparam int POS_SIZE_HI  = 2;
  localparam int POS_SIZE_LO  = 0;

  // Barrier register field positions.
  localparam int POS_BAR_IDLE = 0;
  localparam int POS_BAR_T_HI = 2;
  localparam int POS_BAR_T_LO = 1;
  localparam int POS_BAR_EN   = 0;

  // Reset values.
  localparam logic [6:0] AHB3_PROT_RST  = 7'h43;
  localparam logic       AHB5_NONSEC_RST = 1'h1;
  localparam logic       AHB5_MSEL_RST   = 1'h1;
  localparam logic [3:0] AHB5_HPROT_RST  = 4'h0;
  localparam logic [2:0] APB4_PROT_RST   = 3'h0;
  localparam logic [1:0] INC_RST         = 2'h0;
  localparam logic [2:0] SIZE_RST        = 3'h2;
  localparam logic [1:0] BAR_TYPE_RST    = 2'h0;
  localparam logic       BAR_EN_RST      = 1'h0;

  // Encodings.
  localparam logic [2:0] SIZE_BYTE   = 3'h0;
  localparam logic [2:0] SIZE_HALF   = 3'h1;
  localparam logic [2:0] SIZE_WORD   = 3'h2;
  localparam logic [1:0] INC_OFF     = 2'h0;
  localparam logic [1:0] INC_SINGLE  = 2'h1;
  localparam logic [1:0] INC_PACKED  = 2'h2;
  localparam logic [1:0] BAR_MEMORY  = 2'h1;
  localparam logic [1:0] BAR_SYNC    = 2'h3;

  typedef enum logic [0:0] {
    BAR_IDLE = 1'b0,
    BAR_WAIT = 1'b1
  } mapbam_bar_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mapbam_bus_req_s;

  typedef struct packed {
    logic [6:0] hprot;
    logic       hnonsec;
    logic [3:0] hmaster;
    logic [2:0] hsize;
  } mapbam_ahb5_attr_s;

endpackage

/* File: hw/mapbam_top.sv */
`timescale 1ns/1ps
`default_nettype none

module mapbam_top
  import mapbam_pkg::*;
#(
  parameter bit         AHB3_SDE_MIRROR = 1'b1,
  parameter bit         SECURE_DEBUG    = 1'b1,
  parameter bit         PACKED_EN       = 1'b1,
  parameter bit         MSEL_EN         = 1'b1,
  parameter bit         NONSEC_EN       = 1'b1,
  parameter logic [3:0] OWN_MASTER_ID   = 4'h1,
  parameter logic [3:0] SECOND_MASTER_ID = 4'h2
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire mapbam_bus_req_s   bus_req_i,
  output logic [31:0]            rdata_o,
  input  wire logic              secure_invasive_debug_auth_i,
  output logic                   bar_req_o,
  output logic [1:0]             bar_type_o,
  input  wire logic              bar_ack_i,
  output logic [3:0]             ahb3_hprot_o,
  output logic [2:0]             ahb3_hsize_o,
  output logic [1:0]             ahb3_addr_inc_o,
  output mapbam_ahb5_attr_s      ahb5_attr_o,
  output logic [1:0]             ahb5_addr_inc_o,
  output logic [2:0]             apb4_pprot_o,
  input  wire logic              apb4_req_i,
  input  wire logic              apb4_data_reg_i,
  output logic                   apb4_start_o,
  output logic                   apb4_err_o
);

  function automatic logic size_ok(input logic [2:0] v);
    size_ok = (v == SIZE_BYTE) || (v == SIZE_HALF) || (v == SIZE_WORD);
  endfunction

  function automatic logic inc_ok(input logic [1:0] v);
    inc_ok = (v == INC_OFF) || (v == INC_SINGLE) || (PACKED_EN && (v == INC_PACKED));
  endfunction

  logic              wr_ahb3;
  logic              wr_ahb5;
  logic              wr_apb4;
  logic              wr_bar;
  logic              wr_barc;
  logic [31:0]       wd;
  logic              sde_meta;
  logic              sde_sync;
  logic              sde_ahb3;
  logic              sde_sec;
  logic [6:0]        ahb3_prot;
  logic [1:0]        ahb3_inc;
  logic [2:0]        ahb3_size;
  logic              ahb5_nonsec;
  logic              ahb5_msel;
  logic [3:0]        ahb5_hp;
  logic [1:0]        ahb5_inc;
  logic [2:0]        ahb5_size;
  logic [2:0]        apb4_prot;
  logic              bar_en;
  logic [1:0]        bar_type;
  mapbam_bar_state_e bar_state;
  logic              bar_start;
  logic [31:0]       next_rdata;
  logic [31:0]       cw_ahb3;
  logic [31:0]       cw_ahb5;
  logic [31:0]       cw_apb23;
  logic [31:0]       cw_apb4;
  logic [31:0]       bar_word;

  assign wd      = bus_req_i.wdata;
  assign wr_ahb3 = bus_req_i.wr && (bus_req_i.addr == OFS_CW_AHB3);
  assign wr_ahb5 = bus_req_i.wr && (bus_req_i.addr == OFS_CW_AHB5);
  assign wr_apb4 = bus_req_i.wr && (bus_req_i.addr == OFS_CW_APB4);
  assign wr_bar  = bus_req_i.wr && (bus_req_i.addr == OFS_BARRIER);
  assign wr_barc = bus_req_i.wr && (bus_req_i.addr == OFS_BAR_CTRL);

  // The authentication level comes from outside this clock domain.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sde_meta <= 1'b0;
      sde_sync <= 1'b0;
    end else begin
      sde_meta <= secure_invasive_debug_auth_i;
      sde_sync <= sde_meta;
    end
  end

  assign sde_ahb3 = AHB3_SDE_MIRROR ? sde_sync : 1'b0;
  assign sde_sec  = SECURE_DEBUG ? sde_sync : 1'b0;

  // AHB3 control word.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ahb3_prot <= AHB3_PROT_RST;
      ahb3_inc  <= INC_RST;
      ahb3_size <= SIZE_RST;
    end else if (wr_ahb3) begin
      ahb3_prot <= wd[POS_PROT_HI:POS_PROT_LO];
      if (inc_ok(wd[POS_INC_HI:POS_INC_LO])) begin
        ahb3_inc <= wd[POS_INC_HI:POS_INC_LO];
      end
      if (size_ok(wd[POS_SIZE_HI:POS_SIZE_LO])) begin
        ahb3_size <= wd[POS_SIZE_HI:POS_SIZE_LO];
      end
    end
  end

  // AHB5 control word. Unsupported increment and size codes keep the old value,
  // so the bus never sees an encoding it cannot carry.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ahb5_nonsec <= AHB5_NONSEC_RST;
      ahb5_msel   <= AHB5_MSEL_RST;
      ahb5_hp     <= AHB5_HPROT_RST;
      ahb5_inc    <= INC_RST;
      ahb5_size   <= SIZE_RST;
    end else if (wr_ahb5) begin
      ahb5_nonsec <= wd[POS_NONSEC];
      ahb5_msel   <= wd[POS_MSEL];
      ahb5_hp     <= wd[POS_PROT_LO+3:POS_PROT_LO];
      if (inc_ok(wd[POS_INC_HI:POS_INC_LO])) begin
        ahb5_inc <= wd[POS_INC_HI:POS_INC_LO];
      end
      if (size_ok(wd[POS_SIZE_HI:POS_SIZE_LO])) begin
        ahb5_size <= wd[POS_SIZE_HI:POS_SIZE_LO];
      end
    end
  end

  // APB4 control word; the APB2/APB3 word holds no writable state.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      apb4_prot <= APB4_PROT_RST;
    end else if (wr_apb4) begin
      apb4_prot <= wd[POS_PROT_LO+6:POS_PROT_LO+4];
    end
  end

  // Barrier enable.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bar_en <= BAR_EN_RST;
    end else if (wr_barc) begin
      bar_en <= wd[POS_BAR_EN];
    end
  end

  // A barrier is issued only when enabled, idle and of a defined type.
  // Writes while one is outstanding are dropped rather than queued.
  assign bar_start = wr_bar && bar_en && (bar_state == BAR_IDLE) &&
                     ((wd[POS_BAR_T_HI:POS_BAR_T_LO] == BAR_MEMORY) ||
                      (wd[POS_BAR_T_HI:POS_BAR_T_LO] == BAR_SYNC));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bar_type <= BAR_TYPE_RST;
    end else if (wr_bar && bar_en && (bar_state == BAR_IDLE)) begin
      bar_type <= wd[POS_BAR_T_HI:POS_BAR_T_LO];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bar_state <= BAR_IDLE;
    end else begin
      case (bar_state)
        BAR_IDLE: begin
          if (bar_start) begin
            bar_state <= BAR_WAIT;
          end
        end
        BAR_WAIT: begin
          if (bar_ack_i) begin
            bar_state <= BAR_IDLE;
          end
        end
        default: begin
          bar_state <= BAR_IDLE;
        end
      endcase
    end
  end

  assign bar_req_o  = (bar_state == BAR_WAIT);
  assign bar_type_o = bar_type;

  // Bus attribute outputs.
  assign ahb3_hprot_o    = ahb3_prot[3:0];
  assign ahb3_hsize_o    = ahb3_size;
  assign ahb3_addr_inc_o = ahb3_inc;

  always_comb begin
    ahb5_attr_o.hprot   = {ahb5_hp[3], 1'b0, ahb5_hp[3], ahb5_hp[3],
                           ahb5_hp[2], ahb5_hp[1], ahb5_hp[0]};
    ahb5_attr_o.hnonsec = NONSEC_EN ? ahb5_nonsec : 1'b1;
    ahb5_attr_o.hmaster = (MSEL_EN && !ahb5_msel) ? SECOND_MASTER_ID : OWN_MASTER_ID;
    ahb5_attr_o.hsize   = ahb5_size;
  end
  assign ahb5_addr_inc_o = ahb5_inc;

  // A secure request is only honoured when secure debug is enabled.
  assign apb4_pprot_o = apb4_prot;
  assign apb4_start_o = apb4_req_i && (apb4_prot[1] || sde_sec);
  assign apb4_err_o   = apb4_req_i && apb4_data_reg_i && !apb4_prot[1] && !sde_sec;

  // Read views; every field not listed stays zero.
  always_comb begin
    cw_ahb3 = 32'h0;
    cw_ahb3[POS_PROT_HI:POS_PROT_LO] = ahb3_prot;
    cw_ahb3[POS_SDE]                 = sde_ahb3;
    cw_ahb3[POS_INC_HI:POS_INC_LO]   = ahb3_inc;
    cw_ahb3[POS_SIZE_HI:POS_SIZE_LO] = ahb3_size;
    cw_ahb5 = 32'h0;
    cw_ahb5[POS_NONSEC]              = NONSEC_EN ? ahb5_nonsec : 1'b0;
    cw_ahb5[POS_MSEL]                = MSEL_EN ? ahb5_msel : 1'b0;
    cw_ahb5[POS_PROT_LO+3:POS_PROT_LO] = ahb5_hp;
    cw_ahb5[POS_SDE]                 = sde_sec;
    cw_ahb5[POS_INC_HI:POS_INC_LO]   = ahb5_inc;
    cw_ahb5[POS_SIZE_HI:POS_SIZE_LO] = ahb5_size;
    cw_apb23 = 32'h0;
    cw_apb23[POS_INC_HI:POS_INC_LO]   = INC_OFF;
    cw_apb23[POS_SIZE_HI:POS_SIZE_LO] = SIZE_WORD;
    cw_apb4 = 32'h0;
    cw_apb4[POS_PROT_LO+6:POS_PROT_LO+4] = apb4_prot;
    cw_apb4[POS_SDE]                  = sde_sec;
    cw_apb4[POS_INC_HI:POS_INC_LO]    = INC_OFF;
    cw_apb4[POS_SIZE_HI:POS_SIZE_LO]  = SIZE_WORD;
    bar_word = 32'h0;
    bar_word[POS_BAR_T_HI:POS_BAR_T_LO] = bar_type;
    bar_word[POS_BAR_IDLE]              = (bar_state == BAR_IDLE);
  end

  always_comb begin
    case (bus_req_i.addr)
      OFS_CW_AHB3:  next_rdata = cw_ahb3;
      OFS_CW_AHB5:  next_rdata = cw_ahb5;
      OFS_CW_APB23: next_rdata = cw_apb23;
      OFS_CW_APB4:  next_rdata = cw_apb4;
      OFS_BARRIER:  next_rdata = bar_word;
      OFS_BAR_CTRL: next_rdata = {31'h0, bar_en};
      default:      next_rdata = 32'h0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0;
    end else if (bus_req_i.rd) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0;
    end
  end

  bar_res0_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_BARRIER) |=> (rdata_o[31:3] == 29'h0))
    else $error("Barrier reserved bits not zero.");

  bar_type_ok_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(bar_req_o) |-> (bar_type_o == BAR_MEMORY || bar_type_o == BAR_SYNC))
    else $error("Barrier issued with reserved type.");

  bar_status_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_BARRIER) |=> (rdata_o[0] == !$past(bar_req_o)))
    else $error("Barrier idle bit wrong.");

  bar_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_bar && !bar_en && !bar_req_o) |=> !bar_req_o)
    else $error("Barrier issued while disabled.");

  ahb3_prot_rst_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(srst_i) |-> (ahb3_prot == AHB3_PROT_RST && ahb3_hprot_o == 4'h3))
    else $error("AHB3 protection reset value wrong.");

  ahb3_sde_ro_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_AHB3) |=> (rdata_o[POS_SDE] == $past(sde_ahb3)))
    else $error("AHB3 secure enable bit not read-only.");

  size_keep_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_ahb3 && !size_ok(wd[2:0])) |=> $stable(ahb3_hsize_o))
    else $error("Illegal AHB3 size accepted.");

  hnonsec_rst_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(srst_i) |-> ahb5_attr_o.hnonsec)
    else $error("Non-secure output not one after reset.");

  hprot_tie_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (ahb5_attr_o.hprot[6] == ahb5_attr_o.hprot[4]) && (ahb5_attr_o.hprot[4] == ahb5_attr_o.hprot[3])
    && !ahb5_attr_o.hprot[5])
    else $error("AHB5 protection mapping wrong.");

  apb_fixed_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_APB23) |=> (rdata_o == 32'h2))
    else $error("APB2/3 control word not fixed.");

  apb4_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (apb4_req_i && !apb4_pprot_o[1] && !sde_sec) |-> (!apb4_start_o && (apb4_err_o == apb4_data_reg_i)))
    else $error("Secure APB4 transfer not blocked.");

  cw_res0_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_AHB5) |=> (rdata_o[22:6] == 17'h0 && !rdata_o[3]))
    else $error("AHB5 reserved fields not zero.");

  hprot_map_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_ahb5 |=> (ahb5_attr_o.hprot == {$past(wd[POS_PROT_LO+3]), 1'b0, $past(wd[POS_PROT_LO+3]),
                 $past(wd[POS_PROT_LO+3]), $past(wd[POS_PROT_LO+2:POS_PROT_LO])}))
    else $error("AHB5 protection does not follow the control word.");

  hnonsec_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_ahb5 |=> (ahb5_attr_o.hnonsec == (NONSEC_EN ? $past(wd[POS_NONSEC]) : 1'b1)))
    else $error("Non-secure output does not follow bit 30.");

  hmaster_sel_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_ahb5 |=> (ahb5_attr_o.hmaster ==
                 ((MSEL_EN && !$past(wd[POS_MSEL])) ? SECOND_MASTER_ID : OWN_MASTER_ID)))
    else $error("Master identity does not follow bit 29.");

  hsize_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_ahb5 && size_ok(wd[POS_SIZE_HI:POS_SIZE_LO])) |=>
    (ahb5_attr_o.hsize == $past(wd[POS_SIZE_HI:POS_SIZE_LO])))
    else $error("Legal AHB5 size not taken.");

  inc_keep_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_ahb5 && !inc_ok(wd[POS_INC_HI:POS_INC_LO])) |=> $stable(ahb5_addr_inc_o))
    else $error("Unsupported AHB5 increment accepted.");

  ahb5_sde_ro_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_AHB5) |=> (rdata_o[POS_SDE] == $past(sde_sec)))
    else $error("AHB5 secure enable bit not read-only.");

  pprot_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wr_apb4 |=> (apb4_pprot_o == $past(wd[POS_PROT_LO+6:POS_PROT_LO+4])))
    else $error("APB4 protection does not follow bits 30:28.");

  pprot_pass_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (apb4_req_i && !apb4_pprot_o[1] && sde_sec) |-> (apb4_start_o && !apb4_err_o))
    else $error("Secure APB4 transfer not started.");

  apb4_fixed_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_APB4) |=>
    (rdata_o[POS_INC_HI:POS_INC_LO] == INC_OFF && rdata_o[POS_SIZE_HI:POS_SIZE_LO] == SIZE_WORD))
    else $error("APB4 increment or size not fixed.");

  ahb3_res0_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bus_req_i.rd && bus_req_i.addr == OFS_CW_AHB3) |=> (rdata_o[22:6] == 17'h0 && !rdata_o[3]))
    else $error("AHB3 reserved fields not zero.");

  bar_launch_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    bar_start |=> (bar_req_o && bar_type_o == $past(wd[POS_BAR_T_HI:POS_BAR_T_LO])))
    else $error("Barrier not launched.");

  bar_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bar_req_o && !bar_ack_i) |=> (bar_req_o && $stable(bar_type_o)))
    else $error("Barrier dropped before acknowledge.");

  bar_release_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (bar_req_o && bar_ack_i) |=> !bar_req_o)
    else $error("Barrier held after acknowledge.");

endmodule

`default_nettype wire

/* File: tb/mapbam_ic_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Interconnect stand-in that completes a barrier after a chosen number of cycles.
module mapbam_ic_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [7:0] dly_i,
  output logic            ack_o
);
  logic [7:0] cnt;
  logic       done;

  // The done flag holds off a second pulse while the request is still seen high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= 8'h00;
      done  <= 1'b0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (!req_i) begin
        cnt  <= 8'h00;
        done <= 1'b0;
      end else if (!done) begin
        if (cnt >= dly_i) begin
          ack_o <= 1'b1;
          done  <= 1'b1;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: tb/mapbam_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mapbam_top_tb
  import mapbam_pkg::*;
;
  localparam logic [3:0] OWN_ID = 4'h5;
  localparam logic [3:0] SEC_ID = 4'ha;
  localparam logic [7:0] OFS [4] = '{OFS_CW_AHB3, OFS_CW_AHB5, OFS_CW_APB23, OFS_CW_APB4};

  logic              clk_sys_i;
  logic              srst_i;
  mapbam_bus_req_s   bus_req_i;
  logic [31:0]       rdata_o;
  logic              secure_invasive_debug_auth_i;
  logic              bar_req_o;
  logic [1:0]        bar_type_o;
  logic              bar_ack_i;
  logic [3:0]        ahb3_hprot_o;
  logic [2:0]        ahb3_hsize_o;
  logic [1:0]        ahb3_addr_inc_o;
  mapbam_ahb5_attr_s ahb5_attr_o;
  logic [1:0]        ahb5_addr_inc_o;
  logic [2:0]        apb4_pprot_o;
  logic              apb4_req_i;
  logic              apb4_data_reg_i;
  logic              apb4_start_o;
  logic              apb4_err_o;
  logic [7:0]        ack_dly;
  logic [31:0]       seed;
  logic [31:0]       cw [4];
  int                errors;
  int                n_tests;

  mapbam_top #(.OWN_MASTER_ID(OWN_ID), .SECOND_MASTER_ID(SEC_ID)) dut (
    .clk_sys_i, .srst_i, .bus_req_i, .rdata_o, .secure_invasive_debug_auth_i,
    .bar_req_o, .bar_type_o, .bar_ack_i, .ahb3_hprot_o, .ahb3_hsize_o, .ahb3_addr_inc_o,
    .ahb5_attr_o, .ahb5_addr_inc_o, .apb4_pprot_o, .apb4_req_i, .apb4_data_reg_i,
    .apb4_start_o, .apb4_err_o
  );

  mapbam_ic_model ic (.clk_i(clk_sys_i), .rst_i(srst_i), .req_i(bar_req_o), .dly_i(ack_dly), .ack_o(bar_ack_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Illegal size or increment codes leave the stored field as it was.
  function automatic logic [31:0] nxt(input int k, input logic [31:0] w, input logic [31:0] o);
    logic [31:0] r;
    r = 32'h2;
    if (k < 2) begin
      r[2:0] = (w[2:0] <= 3'h2) ? w[2:0] : o[2:0];
      r[5:4] = (w[5:4] != 2'h3) ? w[5:4] : o[5:4];
    end
    if (k == 0) r[30:24] = w[30:24];
    if (k == 1) r[30:29] = w[30:29];
    if (k == 1) r[27:24] = w[27:24];
    if (k == 3) r[30:28] = w[30:28];
    return r;
  endfunction

  function automatic logic [31:0] rv(input int k);
    logic [31:0] r;
    r = cw[k];
    if (k != 2) r[23] = secure_invasive_debug_auth_i;
    return r;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    bus_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    bus_req_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    bus_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys_i);
    bus_req_i <= '0;
    #1;
    check(rdata_o, exp);
  endtask

  // The authentication level passes a two-flop synchroniser, so allow it to land.
  task automatic set_auth(input logic v);
    @(posedge clk_sys_i);
    secure_invasive_debug_auth_i <= v;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic out_chk;
    logic [31:0] h;
    h = cw[1];
    #1;
    check(32'(ahb3_hprot_o), 32'(cw[0][27:24]));
    check(32'({ahb3_hsize_o, ahb3_addr_inc_o}), 32'({cw[0][2:0], cw[0][5:4]}));
    check(32'({ahb5_attr_o, ahb5_addr_inc_o}), 32'({h[27], 1'b0, h[27], h[27], h[26:24], h[30],
          (h[29] ? OWN_ID : SEC_ID), h[2:0], h[5:4]}));
    check(32'(apb4_pprot_o), 32'(cw[3][30:28]));
  endtask

  task automatic bar_run(input logic [31:0] d, input logic [7:0] dl, input logic [1:0] t);
    int n;
    ack_dly = dl;
    wr(OFS_BARRIER, d);
    #1;
    check(32'({bar_req_o, bar_type_o}), 32'({1'b1, t}));
    if (dl > 8'd8) begin
      rd(OFS_BARRIER, {29'h0, t, 1'b0});
      wr(OFS_BARRIER, 32'h5);
      #1;
      check(32'(bar_type_o), 32'(t));
    end
    n = 0;
    while (bar_req_o === 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(32'(bar_req_o), 32'h0);
    rd(OFS_BARRIER, {29'h0, t, 1'b1});
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    logic [31:0] w;
    int          k;
    bus_req_i = '0;
    srst_i = 1'b1;
    secure_invasive_debug_auth_i = 1'b0;
    apb4_req_i = 1'b0;
    apb4_data_reg_i = 1'b0;
    ack_dly = 8'h00;
    errors = 0;
    n_tests = 0;
    seed = 32'h0e3c91b9;
    cw = '{32'h4300_0002, 32'h6000_0002, 32'h0000_0002, 32'h0000_0002};
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd(OFS[i], rv(i));
    rd(OFS_BARRIER, 32'h1);
    rd(OFS_BAR_CTRL, 32'h0);
    rd(8'h18, 32'h0);
    out_chk();
    $display("test reset done");
    for (int a = 0; a < 2; a++) begin
      set_auth(a[0]);
      for (int i = 0; i < 40; i++) begin
        seed = xs(seed);
        k = int'(seed[1:0]);
        seed = xs(seed);
        w = (i == 0) ? 32'hffff_ffff : seed;
        if (i[0]) w[2:0] = 3'(i % 3);
        wr(OFS[k], w);
        cw[k] = nxt(k, w, cw[k]);
        out_chk();
        rd(OFS[k], rv(k));
      end
    end
    wr(8'h18, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) rd(OFS[i], rv(i));
    $display("test control words done");
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    cw = '{32'h4300_0002, 32'h6000_0002, 32'h0000_0002, 32'h0000_0002};
    out_chk();
    // The synchroniser restarts from zero, so let the authentication level land again.
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) rd(OFS[i], rv(i));
    rd(OFS_BAR_CTRL, 32'h0);
    $display("test mid-run reset done");
    for (int s = 0; s < 2; s++) begin
      set_auth(s[0]);
      for (int p = 0; p < 2; p++) begin
        wr(OFS_CW_APB4, {2'b00, p[0], 29'h2});
        for (int r = 0; r < 4; r++) begin
          @(posedge clk_sys_i);
          apb4_req_i <= r[0];
          apb4_data_reg_i <= r[1];
          #1;
          check(32'({apb4_start_o, apb4_pprot_o[1]}), 32'({r[0] & (p[0] | s[0]), p[0]}));
          check(32'(apb4_err_o), 32'(r[0] & r[1] & !p[0] & !s[0]));
        end
        @(posedge clk_sys_i);
        apb4_req_i <= 1'b0;
      end
    end
    $display("test protection gate done");
    wr(OFS_BARRIER, 32'h3);
    #1;
    check(32'(bar_req_o), 32'h0);
    rd(OFS_BARRIER, 32'h1);
    wr(OFS_BAR_CTRL, 32'h1);
    rd(OFS_BAR_CTRL, 32'h1);
    bar_run(32'h3, 8'd12, 2'h1);
    bar_run(32'h7, 8'd0, 2'h3);
    for (int t = 0; t < 4; t += 2) begin
      wr(OFS_BARRIER, {29'h0, 2'(t), 1'b1});
      #1;
      check(32'(bar_req_o), 32'h0);
      rd(OFS_BARRIER, {29'h0, 2'(t), 1'b1});
    end
    $display("test barrier done");
    print_verdict();
  end
endmodule

`default_nettype wire
